/* hdl/tioc_defs.svh */
// Register map, field positions and reset values of the pin function control block
`ifndef TIOC_DEFS_SVH
`define TIOC_DEFS_SVH

// Byte addresses of the word registers
`define TIOC_ADDR_IOH0 8'h00
`define TIOC_ADDR_IOL0 8'h04
`define TIOC_ADDR_IO1 8'h08
`define TIOC_ADDR_IO2 8'h0C
`define TIOC_ADDR_MODE0 8'h10
`define TIOC_ADDR_START 8'h14
`define TIOC_ADDR_GRB0 8'h18
`define TIOC_ADDR_GRD0 8'h1C
`define TIOC_ADDR_GRB1 8'h20
`define TIOC_ADDR_GRB2 8'h24
`define TIOC_ADDR_STS 8'h28
`define TIOC_ADDR_CLR 8'h2C
`define TIOC_ADDR_IEN 8'h30

// Field positions
`define TIOC_FN_HI 7
`define TIOC_FN_LO 4
`define TIOC_BUF_B_BIT 5

// Reset values
`define TIOC_IOC_RST 8'h00
`define TIOC_MODE_RST 8'hC0
`define TIOC_GR_RST 16'h0000

`endif

/* hdl/tioc_pkg.sv */
// Types and mode decoding of the pin function control block
package tioc_pkg;

  // Decoded function of one general register
  typedef enum logic [2:0] {
    FN_OFF  = 3'b000,
    FN_CLR  = 3'b001,
    FN_SET  = 3'b010,
    FN_TGL  = 3'b011,
    FN_CAPR = 3'b100,
    FN_CAPF = 3'b101,
    FN_CAPB = 3'b110,
    FN_NONE = 3'b111
  } tioc_fn_e;

  // AHB-Lite request from the master
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } tioc_ahb_req_s;

  // AHB-Lite response of the slave
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } tioc_ahb_rsp_s;

  // Pin drive: level and output enable
  typedef struct packed {
    logic [3:0] lvl;
    logic [3:0] oe;
  } tioc_pins_s;

  // Field bits 7:4 to function; prohibited capture codes give no function
  function automatic tioc_fn_e tioc_decode(input logic [3:0] f, input logic b6_free);
    if (!f[3]) begin
      return tioc_fn_e'({1'b0, f[1:0]});
    end else if (f[2] && !b6_free) begin
      return FN_NONE;
    end else if (f[1]) begin
      return FN_CAPB;
    end else if (f[0]) begin
      return FN_CAPF;
    end else begin
      return FN_CAPR;
    end
  endfunction

endpackage

/* hdl/tioc_unit.sv */
// Compare and capture logic of one general register and its pin
`timescale 1ns/1ps
module tioc_unit #(
  parameter bit CAP_B6_FREE = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Configuration
  input wire logic [3:0] func_i,
  input wire logic en_i,
  input wire logic run_i,
  // Counter and general register
  input wire logic [15:0] count_i,
  input wire logic [15:0] greg_i,
  // Pin
  input wire logic pin_i,
  output logic lvl_o,
  output logic oe_o,
  // Events
  output logic capt_o,
  output logic match_o
);
  import tioc_pkg::*;

  typedef struct packed {
    logic lvl;
    logic oe;
    logic pin_prev;
    logic eq_prev;
  } tioc_unit_st_s;

  tioc_unit_st_s st_q;
  tioc_unit_st_s st_d;
  tioc_fn_e fn;
  logic eq;

  // Decode, edge detect and pin update
  always_comb begin
    fn = en_i ? tioc_decode(func_i, CAP_B6_FREE) : FN_NONE;
    eq = run_i && (count_i == greg_i);
    match_o = !fn[2] && eq && !st_q.eq_prev;
    case (fn)
      FN_CAPR: begin
        capt_o = run_i && pin_i && !st_q.pin_prev;
      end
      FN_CAPF: begin
        capt_o = run_i && !pin_i && st_q.pin_prev;
      end
      FN_CAPB: begin
        capt_o = run_i && (pin_i ^ st_q.pin_prev);
      end
      default: begin
        capt_o = 1'b0;
      end
    endcase
    st_d = st_q;
    st_d.pin_prev = pin_i;
    st_d.eq_prev = eq;
    st_d.oe = !fn[2] && (fn != FN_OFF);
    if (!fn[2]) begin
      if (!run_i) begin
        st_d.lvl = func_i[2];
      end else if (match_o) begin
        case (fn)
          FN_CLR: begin
            st_d.lvl = 1'b0;
          end
          FN_SET: begin
            st_d.lvl = 1'b1;
          end
          FN_TGL: begin
            st_d.lvl = !st_q.lvl;
          end
          default: begin
            st_d.lvl = st_q.lvl;
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lvl_o = st_q.lvl;
  assign oe_o = st_q.oe;
endmodule

/* hdl/tioc_irq.sv */
// Sticky event status and masked interrupt output
`timescale 1ns/1ps
module tioc_irq (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Events, clears and enables
  input wire logic [3:0] ev_i,
  input wire logic [3:0] clr_i,
  input wire logic [3:0] ien_i,
  // Status and interrupt
  output logic [3:0] sts_o,
  output logic irq_o
);
  typedef struct packed {
    logic [3:0] sts;
    logic irq;
  } tioc_irq_st_s;

  tioc_irq_st_s st_q;
  tioc_irq_st_s st_d;

  // Set wins over a clear in the same cycle
  always_comb begin
    st_d.sts = (st_q.sts & ~clr_i) | ev_i;
    st_d.irq = |(st_d.sts & ien_i);
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sts_o = st_q.sts;
  assign irq_o = st_q.irq;
endmodule

/* hdl/tioc_top.sv */
// Pin function control block: AHB-Lite registers, four compare/capture units
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tioc_defs.svh"
module tioc_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // AHB-Lite slave
  input wire tioc_pkg::tioc_ahb_req_s ahb_i,
  output tioc_pkg::tioc_ahb_rsp_s ahb_o,
  // Counter values of channels 0 to 2
  input wire logic [2:0][15:0] count_i,
  // Pins: 0 ch0_pin_b, 1 ch0_pin_d, 2 ch1_pin_b, 3 ch2_pin_b
  input wire logic [3:0] pin_i,
  output tioc_pkg::tioc_pins_s pins_o,
  // Interrupt
  output logic irq_o
);
  import tioc_pkg::*;

  // Control words: 0 ch0 high, 1 ch0 low, 2 ch1, 3 ch2
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    tioc_ahb_rsp_s rsp;
    logic [3:0][7:0] ioc;
    logic buffer_mode_b;
    logic [2:0] counter_start_bit;
    logic [3:0][15:0] greg;
    logic [3:0] ien;
  } tioc_top_st_s;

  tioc_top_st_s st_q;
  tioc_top_st_s st_d;
  logic [3:0] idx;
  logic [3:0] clr;
  logic [3:0] sts;
  wire [3:0] capt;
  wire [3:0] match;
  wire [3:0] lvl;
  wire [3:0] oe;

  // Counter channel that serves a unit
  function automatic int unsigned unit_ch(input int unsigned u);
    return (u < 2) ? 0 : u - 1;
  endfunction

  // Byte address to register index, 4'hF when unmapped
  function automatic logic [3:0] addr_index(input logic [7:0] a);
    if (a == `TIOC_ADDR_IOH0) begin
      return 4'h0;
    end else if (a == `TIOC_ADDR_IOL0) begin
      return 4'h1;
    end else if (a == `TIOC_ADDR_IO1) begin
      return 4'h2;
    end else if (a == `TIOC_ADDR_IO2) begin
      return 4'h3;
    end else if (a == `TIOC_ADDR_MODE0) begin
      return 4'h4;
    end else if (a == `TIOC_ADDR_START) begin
      return 4'h5;
    end else if (a == `TIOC_ADDR_GRB0) begin
      return 4'h6;
    end else if (a == `TIOC_ADDR_GRD0) begin
      return 4'h7;
    end else if (a == `TIOC_ADDR_GRB1) begin
      return 4'h8;
    end else if (a == `TIOC_ADDR_GRB2) begin
      return 4'h9;
    end else if (a == `TIOC_ADDR_STS) begin
      return 4'hA;
    end else if (a == `TIOC_ADDR_CLR) begin
      return 4'hB;
    end else if (a == `TIOC_ADDR_IEN) begin
      return 4'hC;
    end else begin
      return 4'hF;
    end
  endfunction

  // One unit per general register; D idles in buffer mode
  for (genvar i = 0; i < 4; i++) begin : g_unit
    localparam int unsigned CH = unit_ch(i);
    tioc_unit #(
      .CAP_B6_FREE(i == 3)
    ) u_unit (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .func_i(st_q.ioc[i][`TIOC_FN_HI:`TIOC_FN_LO]),
      .en_i((i != 1) || !st_q.buffer_mode_b),
      .run_i(st_q.counter_start_bit[CH]),
      .count_i(count_i[CH]),
      .greg_i(st_q.greg[i]),
      .pin_i(pin_i[i]),
      .lvl_o(lvl[i]),
      .oe_o(oe[i]),
      .capt_o(capt[i]),
      .match_o(match[i])
    );
  end

  // Sticky status and interrupt
  tioc_irq u_irq (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ev_i(capt | match),
    .clr_i(clr),
    .ien_i(st_q.ien),
    .sts_o(sts),
    .irq_o(irq_o)
  );

  // Bus slave, register writes, capture loads and buffer transfers
  always_comb begin
    st_d = st_q;
    clr = 4'h0;
    idx = addr_index(st_q.addr);
    st_d.wr = 1'b0;
    // Read data phase: one wait state, then data
    if (st_q.rd) begin
      st_d.rd = 1'b0;
      st_d.rsp.hreadyout = 1'b1;
      case (idx)
        4'h0, 4'h1, 4'h2, 4'h3: begin
          st_d.rsp.hrdata = {24'h000000, st_q.ioc[idx[1:0]]};
        end
        4'h4: begin
          st_d.rsp.hrdata = {24'h000000, `TIOC_MODE_RST | {2'b00, st_q.buffer_mode_b, 5'h00}};
        end
        4'h5: begin
          st_d.rsp.hrdata = {29'h00000000, st_q.counter_start_bit};
        end
        4'h6, 4'h7, 4'h8, 4'h9: begin
          st_d.rsp.hrdata = {16'h0000, st_q.greg[2'(idx - 4'h6)]};
        end
        4'hA: begin
          st_d.rsp.hrdata = {28'h0000000, sts};
        end
        4'hC: begin
          st_d.rsp.hrdata = {28'h0000000, st_q.ien};
        end
        default: begin
          st_d.rsp.hrdata = 32'h00000000;
        end
      endcase
    end
    // Address phase taken
    if (ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1]) begin
      st_d.wr = ahb_i.hwrite;
      st_d.rd = !ahb_i.hwrite;
      st_d.addr = ahb_i.haddr[7:0];
      st_d.rsp.hreadyout = ahb_i.hwrite;
    end
    // Write data phase, zero wait
    if (st_q.wr) begin
      case (idx)
        4'h0, 4'h1, 4'h2, 4'h3: begin
          st_d.ioc[idx[1:0]] = ahb_i.hwdata[7:0];
        end
        4'h4: begin
          st_d.buffer_mode_b = ahb_i.hwdata[`TIOC_BUF_B_BIT];
        end
        4'h5: begin
          st_d.counter_start_bit = ahb_i.hwdata[2:0];
        end
        4'h6, 4'h7, 4'h8, 4'h9: begin
          st_d.greg[2'(idx - 4'h6)] = ahb_i.hwdata[15:0];
        end
        4'hB: begin
          clr = ahb_i.hwdata[3:0];
        end
        4'hC: begin
          st_d.ien = ahb_i.hwdata[3:0];
        end
        default: begin
          st_d.ien = st_q.ien;
        end
      endcase
    end
    // Capture loads the counter, overriding a same-cycle write
    for (int i = 0; i < 4; i++) begin
      if (capt[i]) begin
        st_d.greg[i] = count_i[unit_ch(i)];
      end
    end
    // Buffer mode: B capture pushes old B to D, B match reloads B from D
    if (st_q.buffer_mode_b) begin
      if (capt[0]) begin
        st_d.greg[1] = st_q.greg[0];
      end
      if (match[0]) begin
        st_d.greg[0] = st_q.greg[1];
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
      st_q.rsp.hreadyout <= 1'b1;
      st_q.ioc <= {4{`TIOC_IOC_RST}};
      st_q.greg <= {4{`TIOC_GR_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  assign ahb_o = st_q.rsp;
  assign pins_o = '{lvl: lvl, oe: oe};
endmodule

/* verification/tioc_monitor.sv */
// Checker of bus timing, pin drive and events at the top ports
`timescale 1ns/1ps
module tioc_monitor (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Bus, pins and interrupt
  input wire tioc_pkg::tioc_ahb_req_s ahb_i,
  input wire tioc_pkg::tioc_ahb_rsp_s ahb_o,
  input wire logic [3:0] pin_i,
  input wire tioc_pkg::tioc_pins_s pins_o,
  input wire logic irq_o
);
  import tioc_pkg::*;
  logic [3:0][3:0] fn_q;
  logic [2:0] run_q;
  logic [3:0] ien_q;
  logic buffer_mode_b_q;
  logic wp_q;
  logic [7:0] wa_q;
  logic [3:0] ru, oe_x, stp, b6, m_lo, m_hi, ok, c_r, c_f, c_b;
  wire tk = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];
  // Shadow of control registers from observed writes
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fn_q <= '0;
      run_q <= '0;
      ien_q <= '0;
      buffer_mode_b_q <= 1'b0;
      wp_q <= 1'b0;
    end else begin
      wp_q <= tk && ahb_i.hwrite;
      wa_q <= ahb_i.haddr[7:0];
      if (wp_q && wa_q[7:4] == 4'h0) fn_q[wa_q[3:2]] <= ahb_i.hwdata[7:4];
      if (wp_q && wa_q == 8'h10) buffer_mode_b_q <= ahb_i.hwdata[5];
      if (wp_q && wa_q == 8'h14) run_q <= ahb_i.hwdata[2:0];
      if (wp_q && wa_q == 8'h30) ien_q <= ahb_i.hwdata[3:0];
    end
  end
  // Expected enables and event conditions per unit
  always_comb begin
    ru = {run_q[2], run_q[1], run_q[0], run_q[0]};
    for (int u = 0; u < 4; u++) begin
      oe_x[u] = !fn_q[u][3] && fn_q[u][1:0] != 2'b00 && !(u == 1 && buffer_mode_b_q);
      stp[u] = oe_x[u] && !ru[u];
      b6[u] = fn_q[u][2];
      m_lo[u] = ru[u] && !fn_q[u][3] && fn_q[u][1:0] == 2'b01;
      m_hi[u] = ru[u] && !fn_q[u][3] && fn_q[u][1:0] == 2'b10;
      ok[u] = ru[u] && ien_q[u] && fn_q[u][3] && (!fn_q[u][2] || u == 3) && !(u == 1 && buffer_mode_b_q);
      c_r[u] = ok[u] && fn_q[u][1:0] == 2'b00;
      c_f[u] = ok[u] && fn_q[u][1:0] == 2'b01;
      c_b[u] = ok[u] && fn_q[u][1];
    end
  end
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_rst; $fell(sys_rst_i) |-> pins_o == 8'h00 && !irq_o && ahb_o.hreadyout; endproperty
  a_rst: assert property (p_rst) else $error("not cleared by reset");
  property p_oe; pins_o.oe == $past(oe_x); endproperty
  a_oe: assert property (p_oe) else $error("enable wrong for code");
  property p_init; ((pins_o.lvl ^ $past(b6)) & $past(stp)) == 4'h0; endproperty
  a_init: assert property (p_init) else $error("initial level wrong");
  property p_lo; ($past(m_lo) & pins_o.lvl & ~$past(pins_o.lvl)) == 4'h0; endproperty
  a_lo: assert property (p_lo) else $error("level rose in clear code");
  property p_hi; ($past(m_hi) & ~pins_o.lvl & $past(pins_o.lvl)) == 4'h0; endproperty
  a_hi: assert property (p_hi) else $error("level fell in set code");
  property p_cap; |(c_r & pin_i & ~$past(pin_i) | c_f & ~pin_i & $past(pin_i) | c_b & (pin_i ^ $past(pin_i)))
    |-> ##[1:3] irq_o; endproperty
  a_cap: assert property (p_cap) else $error("capture event missing");
  property p_rd; tk && !ahb_i.hwrite |=> !ahb_o.hreadyout ##1 ahb_o.hreadyout; endproperty
  a_rd: assert property (p_rd) else $error("read wait wrong");
  property p_irq; irq_o |-> $past(ien_q) != 4'h0; endproperty
  a_irq: assert property (p_irq) else $error("interrupt while masked");
  property p_resp; ahb_o.hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("bus response not okay");
  cover property (irq_o);
  cover property ($rose(pins_o.lvl[2]));
  cover property (tk && !ahb_i.hwrite);
endmodule

/* verification/tioc_pin_env.sv */
// Model of the external pins around the block
`timescale 1ns/1ps
module tioc_pin_env (
  // Outside drive and block drive
  input wire logic [3:0] drv_i,
  input wire tioc_pkg::tioc_pins_s pins_i,
  // Resolved pin levels
  output logic [3:0] pin_o
);
  import tioc_pkg::*;
  // Block wins where its enable is high
  assign pin_o = (pins_i.oe & pins_i.lvl) | (~pins_i.oe & drv_i);
endmodule

/* verification/tb.sv */
// Testbench of the pin function control block
`timescale 1ns/1ps
module tb;
  import tioc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] ha = 8'h00;
  logic [1:0] ht = 2'b00;
  logic hw = 1'b0;
  logic [31:0] hd = 32'h0;
  logic [2:0][15:0] cnt = '0;
  logic [3:0] drv = 4'h0;
  logic [3:0] pin;
  logic [3:0] f;
  logic irq;
  tioc_ahb_req_s req;
  tioc_ahb_rsp_s rs;
  tioc_pins_s pins;
  int errors = 0;
  int checks = 0;
  int cyc_n = 0;
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h30, 8'h44};
  logic [31:0] rw [9] = '{32'h105, 32'h0A, 32'h1003, 32'h0C, 32'hFF, 32'h12345, 32'hA0005, 32'hFFF,
    32'h1234};
  logic [31:0] rr [9] = '{32'h05, 32'h0A, 32'h03, 32'h0C, 32'hE0, 32'h2345, 32'h05, 32'h0F, 32'h00};
  assign req = {1'b1, 24'h0, ha, ht, hw, 3'h2, hd, rs.hreadyout};
  tioc_top uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ahb_i(req), .ahb_o(rs), .count_i(cnt),
    .pin_i(pin), .pins_o(pins), .irq_o(irq));
  tioc_pin_env env (.drv_i(drv), .pins_i(pins), .pin_o(pin));
  // Clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Cycle limit against hangs
  always @(posedge clk_sys_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Address phase, then data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    ha <= a;
    hw <= w;
    ht <= 2'b10;
    do @(posedge clk_sys_i); while (rs.hreadyout !== 1'b1);
    ht <= 2'b00;
    hd <= d;
    do @(posedge clk_sys_i); while (rs.hreadyout !== 1'b1);
    q = rs.hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(3);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], rw[i]);
      rc(ra[i], rr[i]);
    end
    $display("rows done");
    for (int i = 0; i < 8; i++) begin
      f = 4'(i);
      wr(8'h08, {24'h0, f, 4'h0});
      cyc(3);
      chk(32'(pins.lvl[2]), 32'(f[2]));
      chk(32'(pins.oe[2]), 32'(f[1:0] != 2'b00));
      wr(8'h14, 32'h2);
      cnt[1] <= 16'h0005;
      cyc(4);
      if (f[1:0] != 2'b00) chk(32'(pins.lvl[2]), 32'(f[1] & ~(f[0] & f[2])));
      chk(32'(irq), 32'h1);
      rc(8'h28, 32'h4);
      wr(8'h14, 32'h0);
      cnt[1] <= 16'h0000;
      wr(8'h2C, 32'hF);
    end
    $display("compare done");
    for (int i = 8; i < 15; i++) begin
      f = 4'(i);
      wr(8'h0C, {24'h0, f, 4'h0});
      wr(8'h24, 32'h0);
      wr(8'h14, 32'h4);
      cnt[2] <= 16'h0100;
      drv[3] <= 1'b1;
      cyc(2);
      cnt[2] <= 16'h0200;
      drv[3] <= 1'b0;
      cyc(2);
      wr(8'h14, 32'h0);
      rc(8'h24, f[1:0] == 2'b00 ? 32'h100 : 32'h200);
    end
    wr(8'h2C, 32'hF);
    $display("capture done");
    wr(8'h30, 32'h0);
    wr(8'h08, 32'hC0);
    wr(8'h20, 32'h77);
    wr(8'h10, 32'h20);
    wr(8'h04, 32'h80);
    wr(8'h0C, 32'h80);
    wr(8'h14, 32'h7);
    drv <= 4'hE;
    cyc(3);
    wr(8'h14, 32'h0);
    rc(8'h20, 32'h77);
    rc(8'h28, 32'h8);
    chk(32'(irq), 32'h0);
    wr(8'h30, 32'hF);
    cyc(3);
    chk(32'(irq), 32'h1);
    wr(8'h2C, 32'h8);
    cyc(3);
    chk(32'(irq), 32'h0);
    wr(8'h04, 32'h20);
    cyc(3);
    chk(32'(pins.oe), 32'h0);
    drv <= 4'h0;
    $display("mask done");
    // D follows the low control word while buffer mode is off
    wr(8'h10, 32'h00);
    wr(8'h04, 32'h50);
    cyc(3);
    chk(32'(pins.oe[1]), 32'h1);
    chk(32'(pins.lvl[1]), 32'h1);
    // Buffer mode: B match reloads B from D, D never matches
    wr(8'h10, 32'h20);
    wr(8'h00, 32'h30);
    wr(8'h18, 32'h9);
    wr(8'h1C, 32'h44);
    wr(8'h14, 32'h1);
    cnt[0] <= 16'h0009;
    cyc(2);
    cnt[0] <= 16'h0044;
    cyc(2);
    wr(8'h14, 32'h0);
    cnt[0] <= 16'h0000;
    rc(8'h18, 32'h44);
    rc(8'h1C, 32'h44);
    rc(8'h28, 32'h1);
    wr(8'h2C, 32'hF);
    $display("buffer done");
    // Output enabled just before the mid-run reset
    wr(8'h08, 32'h20);
    cyc(2);
    chk(32'(pins.oe[2]), 32'h1);
    sys_rst_i <= 1'b1;
    cyc(3);
    sys_rst_i <= 1'b0;
    chk(32'(pins.oe), 32'h0);
    rc(8'h08, 32'h0);
    rc(8'h10, 32'hC0);
    $display("reset done");
    wrap_up();
  end
endmodule
bind tioc_top tioc_monitor mon (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ahb_i(ahb_i), .ahb_o(ahb_o),
  .pin_i(pin_i), .pins_o(pins_o), .irq_o(irq_o));
